// ---- hw/bcce_pkg.sv ----
// Shared constants for the branch, call, clear and clear-watchdog executor
package bcce_pkg;

    // ==========================================================
    // Datapath widths
    localparam int PC_W        = 21;
    localparam int STACK_DEPTH = 31;
    localparam int SP_W        = 5;
    localparam int DADDR_W     = 12;

    // ==========================================================
    // Opcode patterns
    localparam logic [7:0]  OPC_BRANCH_ZERO = 8'he0;
    localparam logic [6:0]  OPC_CALL_HI     = 7'h76;
    localparam logic [3:0]  OPC_CALL_LO     = 4'hf;
    localparam logic [6:0]  OPC_CLEAR_REG   = 7'h35;
    localparam logic [15:0] OPC_CLEAR_WDOG  = 16'h0004;
    localparam int          CALL_SHADOW_BIT = 8;
    localparam int          CLEAR_ACC_BIT   = 8;

    // ==========================================================
    // Status field positions
    localparam int STAT_ZERO_BIT   = 2;
    localparam int RST_TIMEOUT_BIT = 3;
    localparam int RST_PWRDN_BIT   = 2;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
    localparam logic [3:0] ACCESS_LOW_BANK  = 4'h0;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_ACCUM   = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_BANKSEL = 8'h08;
    localparam logic [7:0] OFS_SHADOW  = 8'h0c;
    localparam logic [7:0] OFS_TOS     = 8'h10;
    localparam logic [7:0] OFS_PC      = 8'h14;
    localparam logic [7:0] OFS_RSTAT   = 8'h18;
    localparam logic [7:0] OFS_CTRL    = 8'h1c;
    localparam logic [7:0] OFS_SPTR    = 8'h20;

    // ==========================================================
    // Values after reset
    localparam logic [7:0]      RST_ACCUM   = 8'h00;
    localparam logic [7:0]      RST_STATUS  = 8'h00;
    localparam logic [3:0]      RST_BANKSEL = 4'h0;
    localparam logic [1:0]      RST_RSTAT   = 2'h3;
    localparam logic [PC_W-1:0] RST_PC      = 21'h000000;
    localparam logic            RST_RUN     = 1'b0;

    // ==========================================================
    // Instruction phases and sequencer states
    typedef enum logic [1:0] {
        BCCE_Q1 = 2'b00,
        BCCE_Q2 = 2'b01,
        BCCE_Q3 = 2'b10,
        BCCE_Q4 = 2'b11
    } bcce_phase_t;

    typedef enum logic {
        BCCE_EXEC  = 1'b0,
        BCCE_FLUSH = 1'b1
    } bcce_state_t;

endpackage : bcce_pkg

// ---- hw/bcce_qphase.sv ----
// Four-phase instruction cycle generator
`timescale 1ns/100ps
`default_nettype none
module bcce_qphase (
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    // Control
    input  wire logic                 run,
    // Phase
    output bcce_pkg::bcce_phase_t     phase_q
);
    import bcce_pkg::*;

    // ==========================================================
    // Phase counter, held at Q1 while stopped
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            phase_q <= BCCE_Q1;
        end else if (run || phase_q != BCCE_Q1) begin
            phase_q <= bcce_phase_t'(phase_q + 2'd1);
        end
    end

endmodule : bcce_qphase
`default_nettype wire

// ---- hw/bcce_stack.sv ----
// Return address stack
`timescale 1ns/100ps
`default_nettype none
module bcce_stack (
    // Clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          rst_n,
    // Push
    input  wire logic                          push,
    input  wire logic [bcce_pkg::PC_W-1:0]     push_addr,
    // State
    output logic      [bcce_pkg::PC_W-1:0]     top_q,
    output logic      [bcce_pkg::SP_W-1:0]     sptr_q
);
    import bcce_pkg::*;

    logic [PC_W-1:0] mem [STACK_DEPTH];

    // ==========================================================
    // Pointer saturates at full; the top entry is then overwritten
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sptr_q <= '0;
        end else if (push && sptr_q != SP_W'(STACK_DEPTH)) begin
            sptr_q <= sptr_q + 5'd1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            if (sptr_q == SP_W'(STACK_DEPTH)) begin
                mem[STACK_DEPTH-1] <= push_addr;
            end else begin
                mem[sptr_q] <= push_addr;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            top_q <= '0;
        end else if (push) begin
            top_q <= push_addr;
        end
    end

endmodule : bcce_stack
`default_nettype wire

// ---- hw/bcce_exec.sv ----
// Decode and execute of branch-on-zero, call, clear-register and clear-watchdog
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module bcce_exec (
    // Clock and reset
    input  wire logic                             sys_clk,
    input  wire logic                             rst_n,
    // APB slave
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [7:0]                       paddr,
    input  wire logic [31:0]                      pwdata,
    output logic      [31:0]                      prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    // Instruction fetch
    input  wire logic                             fetch_valid,
    input  wire logic [15:0]                      fetch_word,
    input  wire logic [15:0]                      fetch_next_word,
    output logic      [bcce_pkg::PC_W-1:0]        fetch_addr,
    // Data memory write
    output logic                                  dmem_wr_en,
    output logic      [bcce_pkg::DADDR_W-1:0]     dmem_wr_addr,
    output logic      [7:0]                       dmem_wr_data,
    // Watchdog
    output logic                                  watchdog_clear
);
    import bcce_pkg::*;

    // ==========================================================
    // Decode helpers
    function automatic logic is_branch_on_zero(input logic [15:0] w);
        return w[15:8] == OPC_BRANCH_ZERO;
    endfunction : is_branch_on_zero

    function automatic logic is_call(input logic [15:0] w);
        return w[15:9] == OPC_CALL_HI;
    endfunction : is_call

    function automatic logic is_clear_data_register(input logic [15:0] w);
        return w[15:9] == OPC_CLEAR_REG;
    endfunction : is_clear_data_register

    function automatic logic is_clear_watchdog(input logic [15:0] w);
        return w == OPC_CLEAR_WDOG;
    endfunction : is_clear_watchdog

    // ==========================================================
    // State
    bcce_phase_t        phase;
    bcce_state_t        state_q;
    logic [15:0]        iw_q;
    logic [15:0]        iw2_q;
    logic               iw_ok_q;
    logic [7:0]         literal_q;
    logic [PC_W-1:0]    pc_q;
    logic [7:0]         accum_q;
    logic [7:0]         status_q;
    logic [3:0]         bank_select_register_q;
    logic [7:0]         accumulator_shadow_q;
    logic [7:0]         status_shadow_q;
    logic [3:0]         bank_select_shadow_q;
    logic               timeout_flag_q;
    logic               power_down_flag_q;
    logic               run_q;
    logic               push;
    logic               push_done_q;
    logic [PC_W-1:0]    top_of_return_stack;
    logic [SP_W-1:0]    sptr;
    logic [PC_W-1:0]    branch_target;
    logic               zero_set;
    logic               clear_wd;
    logic               apb_wr;
    logic [31:0]        rd_mux;
    logic               rd_hit;

    bcce_qphase u_qphase (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .run     (run_q),
        .phase_q (phase)
    );

    bcce_stack u_stack (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .push      (push),
        .push_addr (pc_q + 21'd4),
        .top_q     (top_of_return_stack),
        .sptr_q    (sptr)
    );

    // ==========================================================
    // Instruction latch in Q1 of an executing cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            iw_q    <= '0;
            iw2_q   <= '0;
            iw_ok_q <= 1'b0;
        end else if (phase == BCCE_Q1 && run_q) begin
            iw_ok_q <= (state_q == BCCE_EXEC) && fetch_valid;
            iw_q    <= fetch_word;
            iw2_q   <= fetch_next_word;
        end
    end

    // Literal read in Q2: branch offset or low call target
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            literal_q <= '0;
        end else if (phase == BCCE_Q2 && iw_ok_q) begin
            literal_q <= iw_q[7:0];
        end
    end

    assign branch_target = pc_q + 21'd2 + {{12{literal_q[7]}}, literal_q, 1'b0};

    // Return push in Q3 of a well-formed call
    assign push = phase == BCCE_Q3 && iw_ok_q && is_call(iw_q)
                  && iw2_q[15:12] == OPC_CALL_LO;

    // ==========================================================
    // Sequencer: a taken branch or a call idles for one whole cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= BCCE_EXEC;
        end else if (phase == BCCE_Q4) begin
            unique case (state_q)
                BCCE_EXEC: begin
                    if (iw_ok_q && is_branch_on_zero(iw_q) && status_q[STAT_ZERO_BIT]) begin
                        state_q <= BCCE_FLUSH;
                    end else if (push_done_q) begin
                        state_q <= BCCE_FLUSH;
                    end
                end
                BCCE_FLUSH: begin
                    state_q <= BCCE_EXEC;
                end
            endcase
        end
    end

    // Call push seen in Q3, held until the next Q3
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            push_done_q <= 1'b0;
        end else if (phase == BCCE_Q3) begin
            push_done_q <= push;
        end
    end

    // ==========================================================
    // Program counter written in Q4
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pc_q <= RST_PC;
        end else if (phase == BCCE_Q4 && state_q == BCCE_EXEC && iw_ok_q) begin
            if (is_branch_on_zero(iw_q)) begin
                if (status_q[STAT_ZERO_BIT]) begin
                    pc_q <= branch_target;
                end else begin
                    pc_q <= pc_q + 21'd2;
                end
            end else if (push_done_q) begin
                pc_q <= {iw2_q[11:0], literal_q, 1'b0};
            end else begin
                pc_q <= pc_q + 21'd2;
            end
        end
    end

    // ==========================================================
    // Shadow copy alongside the push
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            accumulator_shadow_q <= '0;
            status_shadow_q      <= '0;
            bank_select_shadow_q <= '0;
        end else if (push && iw_q[CALL_SHADOW_BIT]) begin
            accumulator_shadow_q <= accum_q;
            status_shadow_q      <= status_q;
            bank_select_shadow_q <= bank_select_register_q;
        end
    end

    // ==========================================================
    // Clear-register write and clear-watchdog pulse in Q4
    assign zero_set = phase == BCCE_Q4 && state_q == BCCE_EXEC && iw_ok_q
                      && is_clear_data_register(iw_q);
    assign clear_wd = phase == BCCE_Q4 && state_q == BCCE_EXEC && iw_ok_q
                      && is_clear_watchdog(iw_q);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            dmem_wr_en   <= 1'b0;
            dmem_wr_addr <= '0;
            dmem_wr_data <= 8'h00;
        end else begin
            dmem_wr_en   <= zero_set;
            dmem_wr_data <= 8'h00;
            if (zero_set) begin
                if (iw_q[CLEAR_ACC_BIT]) begin
                    dmem_wr_addr <= {bank_select_register_q, iw_q[7:0]};
                end else if (iw_q[7]) begin
                    dmem_wr_addr <= {ACCESS_HIGH_BANK, iw_q[7:0]};
                end else begin
                    dmem_wr_addr <= {ACCESS_LOW_BANK, iw_q[7:0]};
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            watchdog_clear <= 1'b0;
        end else begin
            watchdog_clear <= clear_wd;
        end
    end

    // ==========================================================
    // APB slave: one wait state, pready from a flop
    assign apb_wr = psel && penable && pready && pwrite;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (paddr)
            OFS_ACCUM:   rd_mux = {24'h000000, accum_q};
            OFS_STATUS:  rd_mux = {24'h000000, status_q};
            OFS_BANKSEL: rd_mux = {28'h0000000, bank_select_register_q};
            OFS_SHADOW:  rd_mux = {12'h000, bank_select_shadow_q, status_shadow_q,
                                   accumulator_shadow_q};
            OFS_TOS:     rd_mux = {11'h000, top_of_return_stack};
            OFS_PC:      rd_mux = {11'h000, pc_q};
            OFS_RSTAT:   rd_mux = {28'h0000000, timeout_flag_q, power_down_flag_q, 2'b00};
            OFS_CTRL:    rd_mux = {31'h00000000, run_q};
            OFS_SPTR:    rd_mux = {27'h0000000, sptr};
            default:     rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= !rd_hit;
        end else begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end
    end

    // ==========================================================
    // Software registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            accum_q <= RST_ACCUM;
        end else if (apb_wr && paddr == OFS_ACCUM) begin
            accum_q <= pwdata[7:0];
        end
    end

    // Hardware set of zero wins over a software write in the same cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            status_q <= RST_STATUS;
        end else begin
            if (apb_wr && paddr == OFS_STATUS) begin
                status_q <= pwdata[7:0];
            end
            if (zero_set) begin
                status_q[STAT_ZERO_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bank_select_register_q <= RST_BANKSEL;
        end else if (apb_wr && paddr == OFS_BANKSEL) begin
            bank_select_register_q <= pwdata[3:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            timeout_flag_q    <= RST_RSTAT[1];
            power_down_flag_q <= RST_RSTAT[0];
        end else if (clear_wd) begin
            timeout_flag_q    <= 1'b1;
            power_down_flag_q <= 1'b1;
        end else if (apb_wr && paddr == OFS_RSTAT) begin
            timeout_flag_q    <= pwdata[RST_TIMEOUT_BIT];
            power_down_flag_q <= pwdata[RST_PWRDN_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            run_q <= RST_RUN;
        end else if (apb_wr && paddr == OFS_CTRL) begin
            run_q <= pwdata[0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            fetch_addr <= RST_PC;
        end else begin
            fetch_addr <= pc_q;
        end
    end

endmodule : bcce_exec
`default_nettype wire

// ---- verif/bcce_exec_properties.sv ----
// Port-level checks for the branch, call, clear and watchdog executor
`timescale 1ns/100ps
`default_nettype none
module bcce_exec_properties (
    // Clock and reset
    input wire logic                      sys_clk,
    input wire logic                      rst_n,
    // APB
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic [7:0]                paddr,
    input wire logic [31:0]               prdata,
    input wire logic                      pready,
    input wire logic                      pslverr,
    // Execute side
    input wire logic [bcce_pkg::PC_W-1:0] fetch_addr,
    input wire logic                      dmem_wr_en,
    input wire logic [7:0]                dmem_wr_data,
    input wire logic                      watchdog_clear
);
    import bcce_pkg::*;
    // ==========================================================
    // Bus answer
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    apb_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready late after access start");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    idle_data_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside answer");
    unmapped_err_a: assert property (psel && penable && pready && paddr > OFS_SPTR |-> pslverr)
        else $error("unmapped access not refused");
    // ==========================================================
    // Execution
    clear_data_a: assert property (dmem_wr_en |-> dmem_wr_data == 8'h00)
        else $error("clear wrote nonzero data");
    clear_pulse_a: assert property (dmem_wr_en |=> !dmem_wr_en [*3])
        else $error("clear write more than once per cycle");
    wdog_pulse_a: assert property (watchdog_clear |=> !watchdog_clear [*3])
        else $error("watchdog clear more than once per cycle");
    pc_align_a: assert property (fetch_addr[0] == 1'b0)
        else $error("program counter odd");
    pc_step_a: assert property ($changed(fetch_addr) |=> $stable(fetch_addr) [*3])
        else $error("program counter moved within a cycle");
endmodule : bcce_exec_properties

bind bcce_exec bcce_exec_properties u_props (.sys_clk, .rst_n, .psel, .penable, .paddr,
    .prdata, .pready, .pslverr, .fetch_addr, .dmem_wr_en, .dmem_wr_data, .watchdog_clear);
`default_nettype wire

// ---- verif/tb_bcce_exec.sv ----
// Self-checking bench for the branch, call, clear and watchdog executor
`timescale 1ns/100ps
`default_nettype none
module tb_bcce_exec;
    import bcce_pkg::*;
    // ==========================================================
    // Signals
    logic               sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, err_v;
    logic               fetch_valid, dmem_wr_en, watchdog_clear;
    logic [7:0]         paddr, dmem_wr_data;
    logic [31:0]        pwdata, prdata, rd_v;
    logic [15:0]        fetch_word, fetch_next_word;
    logic [PC_W-1:0]    fetch_addr, pc_e;
    logic [DADDR_W-1:0] dmem_wr_addr, wr_addr_seen;
    logic [15:0]        clr_w [4] = '{16'h6a85, 16'h6a12, 16'h6b40, 16'h6bc0};
    logic [11:0]        clr_a [4] = '{12'hf85, 12'h012, 12'h340, 12'h3c0};
    int                 error_cnt = 0, checks = 0, wd_n = 0, wr_n = 0;

    bcce_exec u_dut (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .fetch_valid, .fetch_word, .fetch_next_word, .fetch_addr,
        .dmem_wr_en, .dmem_wr_addr, .dmem_wr_data, .watchdog_clear);

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        if (watchdog_clear === 1'b1) wd_n++;
        if (dmem_wr_en === 1'b1) begin
            wr_n++;
            wr_addr_seen = dmem_wr_addr;
        end
    end
    // ==========================================================
    // Tasks
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk("apb answer", 32'h0, 32'h1);
        rd_v  = prdata;
        err_v = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, rd_v, exp);
    endtask : rd

    // Holds a word for exactly one instruction cycle, so one Q1 edge sees it
    task automatic exec(input logic [15:0] w0, input logic [15:0] w1, input int tail);
        fetch_word      <= w0;
        fetch_next_word <= w1;
        fetch_valid     <= 1'b1;
        repeat (4) @(posedge sys_clk);
        if (tail > 0) begin
            fetch_valid <= 1'b0;
            repeat (tail) @(posedge sys_clk);
        end
    endtask : exec

    task automatic conclude();
        $display("Checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    initial begin
        #20000;
        error_cnt++;
        $display("Error watchdog of the bench expired");
        conclude();
    end
    // ==========================================================
    // Tests
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        fetch_valid = 1'b0;
        fetch_word = 16'h0;
        fetch_next_word = 16'h0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(OFS_RSTAT, 32'hc, "reset status");
        rd(OFS_SPTR, 32'h0, "stack pointer");
        apb(1'b0, 8'h24, 32'h0);
        chk("unmapped error", {31'h0, err_v}, 32'h1);
        apb(1'b1, OFS_PC, 32'h40);
        rd(OFS_PC, 32'h0, "pc read only");
        apb(1'b1, OFS_CTRL, 32'h1);
        apb(1'b1, OFS_RSTAT, 32'h0);
        // Untaken branch: the next word right behind it runs
        exec(16'he005, 16'h0, 0);
        exec(OPC_CLEAR_WDOG, 16'h0, 8);
        pc_e = 21'h4;
        rd(OFS_PC, {11'h0, pc_e}, "pc");
        chk("fetch address", {11'h0, fetch_addr}, {11'h0, pc_e});
        chk("watchdog clears", 32'(wd_n), 32'h1);
        rd(OFS_RSTAT, 32'hc, "reset status");
        // Taken branch: the word right behind it falls in the idle cycle
        apb(1'b1, OFS_STATUS, 32'h4);
        apb(1'b1, OFS_RSTAT, 32'h0);
        exec(16'he010, 16'h0, 0);
        exec(OPC_CLEAR_WDOG, 16'h0, 8);
        pc_e = pc_e + 21'd2 + 21'h20;
        rd(OFS_PC, {11'h0, pc_e}, "pc");
        chk("watchdog clears", 32'(wd_n), 32'h1);
        rd(OFS_RSTAT, 32'h0, "reset status");
        rd(OFS_STATUS, 32'h4, "status");
        exec(16'he080, 16'h0, 8);
        pc_e = pc_e + 21'd2 - 21'd256;
        rd(OFS_PC, {11'h0, pc_e}, "pc");
        // Call with shadow save
        apb(1'b1, OFS_ACCUM, 32'h5a);
        apb(1'b1, OFS_BANKSEL, 32'h3);
        exec(16'hedde, 16'hfabc, 8);
        rd(OFS_TOS, {11'h0, pc_e + 21'd4}, "top of stack");
        rd(OFS_SHADOW, 32'h0003045a, "shadows");
        pc_e = {20'habcde, 1'b0};
        rd(OFS_PC, {11'h0, pc_e}, "pc");
        chk("fetch address", {11'h0, fetch_addr}, {11'h0, pc_e});
        rd(OFS_SPTR, 32'h1, "stack pointer");
        rd(OFS_STATUS, 32'h4, "status");
        // Call without shadow save, largest target, word behind it ignored
        apb(1'b1, OFS_ACCUM, 32'h11);
        exec(16'hecff, 16'hffff, 0);
        exec(OPC_CLEAR_WDOG, 16'h0, 8);
        rd(OFS_TOS, {11'h0, pc_e + 21'd4}, "top of stack");
        rd(OFS_SHADOW, 32'h0003045a, "shadows");
        pc_e = {20'hfffff, 1'b0};
        rd(OFS_PC, {11'h0, pc_e}, "pc");
        chk("watchdog clears", 32'(wd_n), 32'h1);
        // Call whose second word is wrong does nothing
        exec(16'hec12, 16'he012, 8);
        pc_e = pc_e + 21'd2;
        rd(OFS_PC, {11'h0, pc_e}, "pc");
        rd(OFS_SPTR, 32'h2, "stack pointer");
        // Clear-register in both access modes
        apb(1'b1, OFS_STATUS, 32'h1b);
        for (int i = 0; i < 4; i++) begin
            exec(clr_w[i], 16'h0, 8);
            chk("clear address", {20'h0, wr_addr_seen}, {20'h0, clr_a[i]});
        end
        chk("clear writes", 32'(wr_n), 32'h4);
        rd(OFS_STATUS, 32'h1f, "status");
        pc_e = pc_e + 21'd8;
        rd(OFS_PC, {11'h0, pc_e}, "pc");
        conclude();
    end
endmodule : tb_bcce_exec
`default_nettype wire
